// File: design/wcd_decoder.sv
// wiper command decoder: serial link, instruction execution, store timing
`timescale 1ns/1ns
module wcd_decoder #(
    parameter int STORE_CYCLES = wcd_pkg::STORE_CYCLES // nonvolatile write time in cycles
) (
    input wire logic clock, // 25 MHz system clock
    input wire logic reset_n, // async reset, power-on
    input wire logic sclk, // serial clock pin
    input wire logic cs_n, // chip select pin
    input wire logic serial_data_input, // serial data pin
    input wire logic preset_reload_input, // preset pin, active low
    input wire logic wp_n, // write protect pin, active low
    output logic serial_data_output, // serial out value
    output logic serial_data_output_oe, // open-drain enable, high drives
    output logic ready, // ready, low pulse on completion
    output logic [23:0] wiper_position_register // four 6-bit wipers
);
    // ************************************************************
    // input synchronisers
    // ************************************************************
    wcd_pkg::wcd_pins_t pin_meta;
    wcd_pkg::wcd_pins_t pin_sync;
    wcd_pkg::wcd_pins_t pin_prev;
    wire wcd_pkg::wcd_pins_t pin_raw = '{sclk: sclk, cs_n: cs_n, data_in: serial_data_input,
        preset_n: preset_reload_input, wp_n: wp_n};

    // two stages before any logic looks at a pin
    // reset to the idle levels (link clock low, the rest high) so no false edge follows reset
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pin_meta <= 5'h0F;
            pin_sync <= 5'h0F;
            pin_prev <= 5'h0F;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    wire sclk_rise = pin_sync.sclk && !pin_prev.sclk;
    wire sclk_fall = !pin_sync.sclk && pin_prev.sclk;
    wire cs_fall = !pin_sync.cs_n && pin_prev.cs_n;
    wire cs_rise = pin_sync.cs_n && !pin_prev.cs_n;
    wire preset_rise = pin_sync.preset_n && !pin_prev.preset_n;
    wire protect = !pin_sync.wp_n;

    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [1:0] {WCD_BOOT, WCD_IDLE, WCD_STORE} wcd_state_t;
    wcd_state_t state;
    logic [15:0] shift_in;
    logic [15:0] shift_out;
    logic [15:0] last_word;
    logic [5:0] bit_count;
    logic [3:0] repeat_op;
    logic [1:0] repeat_addr;
    logic repeat_valid;
    logic [5:0] wiper [4];
    logic [7:0] nv_store [wcd_pkg::NV_LOCATIONS];
    logic [3:0] store_addr;
    logic [7:0] store_data;
    logic [$clog2(STORE_CYCLES+1)-1:0] store_count;
    logic [2:0] ready_count;
    logic [1:0] boot_index;

    // saturating helpers, used for single and all-channel forms
    function automatic logic [5:0] step_value(input logic [5:0] v, input logic [3:0] op);
        logic [5:0] r;
        r = v;
        unique case (op)
            wcd_pkg::OP_SHR, wcd_pkg::OP_SHR_ALL: r = v >> 1;
            wcd_pkg::OP_DEC, wcd_pkg::OP_DEC_ALL: r = (v == 6'h00) ? v : v - 6'h01;
            wcd_pkg::OP_SHL, wcd_pkg::OP_SHL_ALL:
                r = v[5] ? wcd_pkg::FULL_SCALE : {v[4:0], 1'b0};
            wcd_pkg::OP_INC, wcd_pkg::OP_INC_ALL:
                r = (v == wcd_pkg::FULL_SCALE) ? v : v + 6'h01;
            default: r = v;
        endcase
        return r;
    endfunction : step_value

    function automatic logic is_step(input logic [3:0] op);
        return op inside {wcd_pkg::OP_SHR, wcd_pkg::OP_SHR_ALL, wcd_pkg::OP_DEC,
            wcd_pkg::OP_DEC_ALL, wcd_pkg::OP_SHL, wcd_pkg::OP_SHL_ALL, wcd_pkg::OP_INC,
            wcd_pkg::OP_INC_ALL};
    endfunction : is_step

    // ************************************************************
    // frame decode
    // ************************************************************
    wire wcd_pkg::wcd_word_t word = shift_in;
    wire frame_ok = (bit_count != 6'd0) && (bit_count[3:0] == 4'd0);
    wire bare_strobe = cs_rise && (bit_count == 6'd0);
    wire busy = (state == WCD_STORE);
    // new word, or repeat of a remembered step command
    wire exec_new = cs_rise && frame_ok && (state == WCD_IDLE);
    wire exec_rep = bare_strobe && repeat_valid && (state == WCD_IDLE);
    wire [3:0] exec_op = exec_new ? word.op : repeat_op;
    wire [1:0] exec_ch = exec_new ? word.addr[1:0] : repeat_addr;
    wire exec = exec_new || exec_rep;
    wire single_op = (exec_op == wcd_pkg::OP_SHR) || (exec_op == wcd_pkg::OP_DEC)
        || (exec_op == wcd_pkg::OP_SHL) || (exec_op == wcd_pkg::OP_INC);
    wire store_op = exec_new && !protect
        && (word.op == wcd_pkg::OP_STORE || word.op == wcd_pkg::OP_STORE_DATA);
    wire read_op = exec_new && (word.op == wcd_pkg::OP_READ_NV
        || word.op == wcd_pkg::OP_READ_WIPER);
    wire [7:0] store_value = (word.op == wcd_pkg::OP_STORE_DATA) ? word.data
        : {2'b00, wiper[word.addr[1:0]]};
    wire [3:0] store_where = (word.op == wcd_pkg::OP_STORE) ? {2'b00, word.addr[1:0]}
        : word.addr;
    wire store_done = (state == WCD_STORE) && (store_count == '0);

    // ************************************************************
    // serial shift in and out
    // ************************************************************
    // the lock during a store stops the shifter so nothing queues behind it
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            shift_in <= wcd_pkg::WORD_RESET;
            bit_count <= 6'd0;
        end else if (busy || pin_sync.cs_n) begin
            bit_count <= pin_sync.cs_n ? 6'd0 : bit_count;
        end else if (sclk_rise) begin
            shift_in <= {shift_in[14:0], pin_sync.data_in};
            bit_count <= (bit_count == 6'd63) ? 6'd16 : bit_count + 6'd1;
        end
    end

    // output replays the previous word, or the read result after codes 9 and 10
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            shift_out <= wcd_pkg::WORD_RESET;
            last_word <= wcd_pkg::WORD_RESET;
            serial_data_output <= 1'b1;
            serial_data_output_oe <= 1'b0;
        end else begin
            if (exec_new) begin
                last_word <= read_op ? {word.op, word.addr, (word.op == wcd_pkg::OP_READ_NV)
                    ? nv_store[word.addr] : {2'b00, wiper[word.addr[1:0]]}} : shift_in;
            end
            if (cs_fall) begin
                shift_out <= last_word;
            end else if (sclk_fall && !pin_sync.cs_n) begin
                shift_out <= {shift_out[14:0], 1'b0};
            end
            serial_data_output <= shift_out[15];
            serial_data_output_oe <= !pin_sync.cs_n && !shift_out[15];
        end
    end

    // ************************************************************
    // control sequencing: boot restore, store timer, ready pulse
    // ************************************************************
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= WCD_BOOT;
            boot_index <= 2'd0;
            store_count <= '0;
            store_addr <= 4'h0;
            store_data <= 8'h00;
            ready_count <= 3'd0;
            ready <= 1'b1;
            repeat_valid <= 1'b0;
            repeat_op <= wcd_pkg::OP_NOP;
            repeat_addr <= 2'd0;
        end else begin
            unique case (state)
                WCD_BOOT: begin
                    boot_index <= boot_index + 2'd1;
                    if (boot_index == 2'd3) state <= WCD_IDLE;
                end
                WCD_IDLE: begin
                    if (store_op) begin
                        state <= WCD_STORE;
                        store_count <= ($clog2(STORE_CYCLES+1))'(STORE_CYCLES - 1);
                        store_addr <= store_where;
                        store_data <= store_value;
                    end
                end
                WCD_STORE: begin
                    if (store_count != '0) store_count <= store_count - 1'b1;
                    else state <= WCD_IDLE;
                end
            endcase
            // a fresh word other than a step clears the repeat memory
            if (exec_new) begin
                repeat_valid <= is_step(word.op);
                repeat_op <= word.op;
                repeat_addr <= word.addr[1:0];
            end
            // ready drops low for a few cycles at each completion
            if (store_done || read_op || (preset_rise && state != WCD_BOOT)) begin
                ready_count <= 3'(wcd_pkg::READY_PULSE_CYCLES);
                ready <= 1'b0;
            end else if (ready_count != 3'd0) begin
                ready_count <= ready_count - 3'd1;
                ready <= (ready_count == 3'd1);
            end
        end
    end

    // ************************************************************
    // nonvolatile store array
    // ************************************************************
    // no reset on purpose: an array holds its value, defaults loaded at boot
    always_ff @(posedge clock) begin
        if (state == WCD_BOOT && boot_index == 2'd0) begin
            for (int i = 0; i < wcd_pkg::NV_LOCATIONS; i++) begin
                nv_store[i] <= wcd_pkg::NV_DEFAULT;
            end
        end else if (store_done) begin
            nv_store[store_addr] <= store_data;
        end
    end

    // ************************************************************
    // wiper registers
    // ************************************************************
    // restores and the preset pin still work under write protect; all else is blocked
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 4; i++) wiper[i] <= wcd_pkg::MIDSCALE;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (state == WCD_BOOT && boot_index == 2'd3) begin
                    wiper[i] <= nv_store[i][5:0];
                end else if (!pin_sync.preset_n) begin
                    wiper[i] <= wcd_pkg::MIDSCALE;
                end else if (preset_rise || (exec_new && word.op == wcd_pkg::OP_RESTORE_ALL)) begin
                    wiper[i] <= nv_store[i][5:0];
                end else if (exec_new && word.op == wcd_pkg::OP_RESTORE
                    && word.addr[1:0] == 2'(i)) begin
                    wiper[i] <= nv_store[i][5:0];
                end else if (exec && !protect && is_step(exec_op)
                    && (!single_op || exec_ch == 2'(i))) begin
                    wiper[i] <= step_value(wiper[i], exec_op);
                end else if (exec_new && !protect && word.op == wcd_pkg::OP_WRITE
                    && word.addr[1:0] == 2'(i)) begin
                    wiper[i] <= word.data[5:0];
                end
            end
        end
    end

    // wiper bus, register outputs; zero means the B end
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wiper_position_register <= {4{wcd_pkg::MIDSCALE}};
        end else begin
            wiper_position_register <= {wiper[3], wiper[2], wiper[1], wiper[0]};
        end
    end
endmodule : wcd_decoder

// File: design/wcd_pkg.sv
// package of constants and types for the wiper command decoder
// Operation
// - wiper position follows its volatile wiper register
// - store lasts 25 ms, input locked
// - ready pulses low when store completes
// - codes 0 nop, 1 restore, 8 restore all
// - codes 2 and 3 store to nonvolatile
// - codes 4 and 5 shift right
// - codes 6 and 7 decrement one step
// - codes 12 and 13 shift left
// - codes 14 and 15 increment one step
// - codes 9 and 10 read back on output
// - code 11 writes data to wiper
// - output shifts previous word during frame
// - power-on loads wipers from store
// - preset low midscale, rising edge reloads
// - bare chip-select strobe repeats step command
// - write protect blocks changes except restores and preset midscale
// - factory stored value is midscale 0x20
// - sixteen bits msb first, decode on rise
// - wiper uses six low data bits
// - ready also marks 2, 3, 9, 10, preset
package wcd_pkg;
    // ************************************************************
    // instruction codes
    // ************************************************************
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_RESTORE = 4'h1;
    localparam logic [3:0] OP_STORE = 4'h2;
    localparam logic [3:0] OP_STORE_DATA = 4'h3;
    localparam logic [3:0] OP_SHR = 4'h4;
    localparam logic [3:0] OP_SHR_ALL = 4'h5;
    localparam logic [3:0] OP_DEC = 4'h6;
    localparam logic [3:0] OP_DEC_ALL = 4'h7;
    localparam logic [3:0] OP_RESTORE_ALL = 4'h8;
    localparam logic [3:0] OP_READ_NV = 4'h9;
    localparam logic [3:0] OP_READ_WIPER = 4'hA;
    localparam logic [3:0] OP_WRITE = 4'hB;
    localparam logic [3:0] OP_SHL = 4'hC;
    localparam logic [3:0] OP_SHL_ALL = 4'hD;
    localparam logic [3:0] OP_INC = 4'hE;
    localparam logic [3:0] OP_INC_ALL = 4'hF;
    // ************************************************************
    // values and timing
    // ************************************************************
    localparam logic [5:0] MIDSCALE = 6'h20;
    localparam logic [5:0] FULL_SCALE = 6'h3F;
    localparam logic [7:0] NV_DEFAULT = 8'h20;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam int WORD_BITS = 16;
    localparam int CLOCK_HZ = 25000000;
    localparam int STORE_MS = 25;
    localparam int STORE_CYCLES = (STORE_MS * CLOCK_HZ) / 1000;
    localparam int READY_PULSE_CYCLES = 4;
    localparam int NV_LOCATIONS = 16;
    // decoded instruction word
    typedef struct packed {
        logic [3:0] op;
        logic [3:0] addr;
        logic [7:0] data;
    } wcd_word_t;
    // serial pins as sampled
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic data_in;
        logic preset_n;
        logic wp_n;
    } wcd_pins_t;
endpackage : wcd_pkg

// File: tb/wcd_decoder_props.sv
// assertion checker on the ports of the wiper command decoder
`timescale 1ns/1ns
module wcd_decoder_props #(
    parameter int STORE_CYCLES = wcd_pkg::STORE_CYCLES // store time in cycles
) (
    input wire logic clock, // clock
    input wire logic reset_n, // reset
    input wire logic sclk, // link clock
    input wire logic cs_n, // select
    input wire logic serial_data_input, // data in
    input wire logic preset_reload_input, // preset
    input wire logic wp_n, // protect
    input wire logic serial_data_output, // data out
    input wire logic serial_data_output_oe, // out enable
    input wire logic ready, // completion
    input wire logic [23:0] wiper_position_register // wipers
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    logic [19:0] since; // cycles since a select rise or a preset edge
    // every wiper or ready event must trace back to a recent cause, so count from the last one
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) since <= 20'h00000;
        else if ($rose(cs_n) || $changed(preset_reload_input)) since <= 20'h00000;
        else if (since != 20'hFFFFF) since <= since + 20'h00001;
    end
    property p_oe_idle; cs_n [*5] |-> !serial_data_output_oe; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("output driven while idle");
    property p_oe_low; serial_data_output_oe |-> !serial_data_output; endproperty
    a_oe_low: assert property (p_oe_low) else $error("output enabled on a one");
    property p_preset_mid;
        !preset_reload_input [*6] |-> wiper_position_register == {4{wcd_pkg::MIDSCALE}};
    endproperty
    a_preset_mid: assert property (p_preset_mid) else $error("preset not midscale");
    property p_ready_pulse; $fell(ready) |=> !ready [*3] ##1 ready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready pulse width");
    property p_wiper_cause; $changed(wiper_position_register) |-> since < 20'h0000C; endproperty
    a_wiper_cause: assert property (p_wiper_cause) else $error("wiper moved uncaused");
    property p_ready_cause; $fell(ready) |-> since < STORE_CYCLES + 12; endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("ready fell uncaused");
    property p_preset_ready; $rose(preset_reload_input) |-> ##[1:10] !ready; endproperty
    a_preset_ready: assert property (p_preset_ready) else $error("no ready on preset");
    property p_boot;
        $rose(reset_n) |-> (wiper_position_register == {4{wcd_pkg::MIDSCALE}}) [*6];
    endproperty
    a_boot: assert property (p_boot) else $error("boot wipers not midscale");
    c_ready: cover property ($fell(ready));
    c_preset: cover property ($rose(preset_reload_input));
    c_protect: cover property (!wp_n && $changed(wiper_position_register));
endmodule : wcd_decoder_props
bind wcd_decoder wcd_decoder_props #(.STORE_CYCLES(STORE_CYCLES)) i_wcd_decoder_props (
    .clock(clock), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .wp_n(wp_n), .ready(ready),
    .serial_data_input(serial_data_input), .preset_reload_input(preset_reload_input),
    .serial_data_output(serial_data_output), .serial_data_output_oe(serial_data_output_oe),
    .wiper_position_register(wiper_position_register));

// File: tb/wcd_host_model.sv
// host controller model driving the chip-select serial link
`timescale 1ns/1ns
module wcd_host_model (
    output logic sclk, // link clock, still between frames
    output logic cs_n, // chip select
    output logic data_in, // data to the device
    input wire logic return_line // open-drain return line with pull-up
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        data_in = 1'b0;
    end
    // one frame of n bits, msb first; n of 0 is a bare select strobe
    task automatic xfer(input logic [15:0] word, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        cs_n = 1'b0;
        #320;
        for (int i = n - 1; i >= 0; i--) begin
            data_in = word[i % 16];
            #160 sclk = 1'b1;
            rx = {rx[14:0], return_line};
            #160 sclk = 1'b0;
        end
        #160 cs_n = 1'b1;
        data_in = ~data_in; // a released line keeps no valid level
        #800;
    endtask : xfer
endmodule : wcd_host_model

// File: tb/tb_wcd_decoder.sv
// self-checking bench for the wiper command decoder
`timescale 1ns/1ns
module tb_wcd_decoder;
    localparam int STORE_CYC = 400; // shortened store, still longer than a frame
    logic clock, reset_n, preset_n, wp_n, lock, data_out, data_out_oe, ready;
    wire logic sclk, cs_n, data_in;
    wire logic return_line = data_out_oe ? 1'b0 : 1'b1; // open drain with pull-up
    logic [23:0] wiper, prev, snap;
    logic [23:0] exp_q [$]; // expected wiper values, oldest first
    logic [5:0] w [4]; // expected wipers
    logic [7:0] nv [16]; // expected store contents
    logic [15:0] rx;
    logic [7:0] d;
    logic [3:0] ops [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hC, 4'hD, 4'hE, 4'hF};
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int t0;
    wcd_decoder #(.STORE_CYCLES(STORE_CYC)) i_wcd_decoder (.clock(clock), .reset_n(reset_n),
        .sclk(sclk), .cs_n(cs_n), .serial_data_input(data_in), .preset_reload_input(preset_n),
        .wp_n(wp_n), .serial_data_output(data_out), .serial_data_output_oe(data_out_oe),
        .ready(ready), .wiper_position_register(wiper));
    wcd_host_model i_wcd_host_model (.sclk(sclk), .cs_n(cs_n), .data_in(data_in),
        .return_line(return_line));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic finish_test();
        if (n_errors == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    function automatic logic [23:0] pack();
        return {w[3], w[2], w[1], w[0]};
    endfunction : pack
    task automatic note();
        if (pack() !== snap) exp_q.push_back(pack());
    endtask : note
    // step arithmetic saturates at both ends instead of wrapping
    function automatic logic [5:0] step(input logic [3:0] op, input logic [5:0] v);
        case (op[3:1])
            3'h2: return v >> 1;
            3'h3: return (v == 6'h00) ? v : v - 6'h01;
            3'h6: return v[5] ? 6'h3F : v << 1;
            default: return (v == 6'h3F) ? v : v + 6'h01;
        endcase
    endfunction : step
    // send one word of n bits and note the wiper value it should leave
    task automatic cmd(input logic [3:0] op, input logic [3:0] a, input logic [7:0] dd,
        input int n);
        snap = pack();
        if ((n == 16 || n == 0) && !lock && (wp_n || op == 4'h1 || op == 4'h8)) begin
            case (op)
                4'hB: w[a[1:0]] = dd[5:0];
                4'h1: w[a[1:0]] = nv[a[1:0]][5:0];
                4'h8: for (int i = 0; i < 4; i++) w[i] = nv[i][5:0];
                4'h2: nv[a[1:0]] = {2'b00, w[a[1:0]]};
                4'h3: nv[a] = dd;
                4'h4, 4'h5, 4'h6, 4'h7, 4'hC, 4'hD, 4'hE, 4'hF:
                    for (int i = 0; i < 4; i++) if (op[0] || i == a[1:0]) w[i] = step(op, w[i]);
                default: ;
            endcase
        end
        note();
        @(posedge clock);
        #1;
        i_wcd_host_model.xfer({op, a, dd}, n, rx);
    endtask : cmd
    // wait for the completion pulse of a store, then let frames through again
    task automatic wait_store();
        int n;
        logic in_time;
        n = 0;
        while (ready !== 1'b0 && n < 1000) begin
            @(posedge clock);
            n++;
        end
        in_time = (cycles - t0 >= STORE_CYC) && (cycles - t0 <= STORE_CYC + 12);
        check("store time", 24'(in_time), 24'h1);
        repeat (8) @(posedge clock);
        lock = 1'b0;
    endtask : wait_store
    // compare each wiper change with the oldest note; cut a hang short
    always @(posedge clock) begin
        if (reset_n && wiper !== prev) begin
            if (exp_q.size() == 0) check("spare wiper change", wiper, prev);
            else check("wiper", wiper, exp_q.pop_front());
        end
        prev <= wiper;
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_errors++;
            finish_test();
        end
    end
    initial begin
        void'($urandom(74));
        {reset_n, preset_n, wp_n, lock} = 4'h6;
        for (int i = 0; i < 16; i++) nv[i] = wcd_pkg::NV_DEFAULT;
        for (int i = 0; i < 4; i++) w[i] = wcd_pkg::MIDSCALE;
        repeat (4) @(posedge clock);
        #1 reset_n = 1'b1;
        repeat (12) @(posedge clock);
        check("boot wipers", wiper, {4{wcd_pkg::MIDSCALE}});
        cmd(4'hB, 4'h0, 8'h10, 16);
        cmd(4'h0, 4'h0, 8'h00, 16);
        check("echo word", 24'(rx), 24'h00B010);
        for (int c = 0; c < 4; c++) cmd(4'hB, 4'(c), 8'($urandom), 16);
        cmd(4'hA, 4'h2, 8'h00, 16);
        cmd(4'h0, 4'h0, 8'h00, 16);
        check("wiper read", 24'(rx), 24'({4'hA, 4'h2, 2'b00, w[2]}));
        // park two channels at the ends so the step codes meet saturation
        cmd(4'hB, 4'h3, 8'hFF, 16);
        cmd(4'hB, 4'h0, 8'hC0, 16);
        foreach (ops[k]) begin
            cmd(ops[k], 4'(k % 4), 8'h00, 16);
            cmd(ops[k], 4'(k % 4), 8'h00, 0);
        end
        // top end: step up and shift left must both hold at full scale
        cmd(4'hB, 4'h3, 8'h3F, 16);
        cmd(4'hE, 4'h3, 8'h00, 16);
        cmd(4'hC, 4'h3, 8'h00, 16);
        cmd(4'hB, 4'h1, 8'h05, 15);
        cmd(4'h2, 4'h1, 8'h00, 16);
        t0 = cycles - 20;
        lock = 1'b1;
        cmd(4'hB, 4'h1, 8'h3A, 16);
        wait_store();
        cmd(4'hB, 4'h1, 8'h07, 16);
        cmd(4'h1, 4'h1, 8'h00, 16);
        d = 8'($urandom);
        cmd(4'h3, 4'h2, d, 16);
        t0 = cycles - 20;
        lock = 1'b1;
        wait_store();
        cmd(4'h9, 4'h2, 8'h00, 16);
        cmd(4'h0, 4'h0, 8'h00, 16);
        check("store read", 24'(rx), 24'({4'h9, 4'h2, d}));
        cmd(4'h8, 4'h0, 8'h00, 16);
        // preset low forces midscale, its release reloads from the store
        snap = pack();
        for (int i = 0; i < 4; i++) w[i] = wcd_pkg::MIDSCALE;
        note();
        preset_n = 1'b0;
        repeat (20) @(posedge clock);
        snap = pack();
        for (int i = 0; i < 4; i++) w[i] = nv[i][5:0];
        note();
        #1 preset_n = 1'b1;
        cmd(4'hB, 4'h0, 8'h2B, 16);
        wp_n = 1'b0;
        cmd(4'hB, 4'h0, 8'h11, 16);
        cmd(4'hF, 4'h0, 8'h00, 16);
        cmd(4'hF, 4'h0, 8'h00, 0);
        cmd(4'h1, 4'h0, 8'h00, 16);
        cmd(4'h0, 4'h0, 8'h00, 16);
        wp_n = 1'b1;
        repeat (20) @(posedge clock);
        check("pending changes", 24'(exp_q.size()), 24'h0);
        finish_test();
    end
endmodule : tb_wcd_decoder
